// file: pkg/ddsw_pkg.sv
/*
 Shared types, field positions and reset values for the dual DAC serial
 word decoder. Assumes a 16-bit command word shifted in MSB first.
*/
package ddsw_pkg;
    localparam int WORD_BITS = 16;
    localparam int TGT_HI_POS = 15;
    localparam int SPEED_POS = 14;
    localparam int PWR_POS = 13;
    localparam int TGT_LO_POS = 12;
    localparam int CODE_MSB_POS = 11;
    localparam int CODE_LSB_POS = 4;
    localparam int REF_HI_POS = 1;
    localparam int REF_LO_POS = 0;

    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_LAST = 5'h0F;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] CODE_RESET = 8'h00;

    typedef enum logic [1:0] {
        TGT_B_AND_BUF = 2'h0,
        TGT_BUF_ONLY = 2'h1,
        TGT_A_XFER_B = 2'h2,
        TGT_CONTROL = 2'h3
    } ddsw_target_t;

    typedef enum logic [1:0] {
        REF_EXT_LO = 2'h0,
        REF_INT_1V024 = 2'h1,
        REF_INT_2V048 = 2'h2,
        REF_EXT_HI = 2'h3
    } ddsw_ref_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_WAIT_RISE = 2'h2,
        ST_DONE = 2'h3
    } ddsw_state_t;

    typedef struct packed {
        logic sclk;
        logic din;
        logic cs_n;
    } ddsw_pins_t;

    typedef struct packed {
        ddsw_ref_t ref_sel;
        logic fast;
        logic pdown;
    } ddsw_ctrl_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] buffer;
        ddsw_ctrl_t ctrl;
    } ddsw_dac_t;

    localparam ddsw_pins_t PINS_RESET = '{sclk: 1'h0, din: 1'h0, cs_n: 1'h1};
    localparam ddsw_ctrl_t CTRL_RESET = '{ref_sel: REF_EXT_LO, fast: 1'h0, pdown: 1'h0};
    localparam ddsw_dac_t DAC_RESET = '{first: CODE_RESET, second: CODE_RESET,
                                        buffer: CODE_RESET, ctrl: CTRL_RESET};
endpackage

// file: src/ddsw_sync.sv
/*
 Two-flop synchroniser for the three serial pins.
 Assumes the pins are asynchronous to the core clock.
*/
`timescale 1ns/1ps
module ddsw_sync
    import ddsw_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire ddsw_pins_t pins_in,
    output ddsw_pins_t pins_out
);
    ddsw_pins_t meta_reg;
    ddsw_pins_t meta_next;
    ddsw_pins_t stable_reg;
    ddsw_pins_t stable_next;

    always_comb
    begin
        meta_next = pins_in;
        stable_next = meta_reg;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            meta_reg <= PINS_RESET;
            stable_reg <= PINS_RESET;
        end
        else
        begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign pins_out = stable_reg;
endmodule

// file: src/ddsw_top.sv
/*
 Serial command word decoder for a dual 8-bit DAC: shift register, target
 latches, holding buffer and control register. Assumes the serial clock is
 well below MCLK_IN/4 so every pin edge is seen after synchronisation.
*/
// Behaviour
// R1: Bits shift in MSB first, one per serial clock falling edge after select falls.
// R2: At 16 bits, or an earlier select rise, the word goes to the chosen latch.
// R3: Select 00 writes second output and buffer, 01 buffer, 10 first output plus buffer to second, 11 control.
// R4: Top four bits are target pair, speed and power bits; lower twelve carry data.
// R5: The controller puts the 8-bit code in the top data bits and zeros the low four.
// R6: A control write uses only the two lowest data bits for the reference.
// R7: Reference code 00 external, 01 internal 1.024 V, 10 internal 2.048 V, 11 external.
// R8: The controller picks an external code whenever it drives the reference pin.
// R9: A first-output write takes effect on the serial clock rise after the last bit.
// R10: A transfer write moves both outputs together on that rising edge.
// R11: Simultaneous update is buffer-only write then transfer write; second output holds meanwhile.
// R12: Select 00 updates buffer and second output at word end.
// R13: Speed bit one selects fast settling, zero slow, in every word.
// R14: Power bit one in any word powers down; zero means normal operation.
// R15: The reference setting survives later DAC writes.
// R16: A new select fall restarts bit counting; a short word never merges with the next. The code keeps older bits above a short word's own.
`timescale 1ns/1ps
module ddsw_top
    import ddsw_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic SCLK_IN,
    input wire logic DIN_IN,
    input wire logic CS_N_IN,
    output logic [7:0] OUTPUT_FIRST_CODE_OUT,
    output logic [7:0] OUTPUT_SECOND_CODE_OUT,
    output logic [7:0] BUFFER_CODE_OUT,
    output logic [1:0] REF_SELECT_OUT,
    output logic FAST_SETTLE_OUT,
    output logic POWER_DOWN_OUT,
    output logic WORD_LOADED_OUT
);
    ddsw_pins_t pins_raw;
    ddsw_pins_t pins_s;
    ddsw_pins_t prev_reg;
    ddsw_pins_t prev_next;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    ddsw_state_t state_reg;
    ddsw_state_t state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    ddsw_dac_t dac_reg;
    ddsw_dac_t dac_next;
    logic loaded_reg;
    logic loaded_next;
    logic apply_now;

    // Target decode and field routing of one complete word
    function automatic ddsw_dac_t apply_word(input ddsw_dac_t cur, input logic [15:0] w);
        ddsw_dac_t nxt;
        logic [7:0] code;
        nxt = cur;
        code = w[CODE_MSB_POS:CODE_LSB_POS]; // [R4] [R5]
        nxt.ctrl.fast = w[SPEED_POS]; // [R13]
        nxt.ctrl.pdown = w[PWR_POS]; // [R14]
        unique case (ddsw_target_t'({w[TGT_HI_POS], w[TGT_LO_POS]})) // [R3]
            TGT_B_AND_BUF:
            begin
                nxt.second = code; // [R12]
                nxt.buffer = code;
            end
            TGT_BUF_ONLY: nxt.buffer = code; // [R11]
            TGT_A_XFER_B:
            begin
                nxt.first = code; // [R9]
                nxt.second = cur.buffer; // [R10]
            end
            TGT_CONTROL: nxt.ctrl.ref_sel = ddsw_ref_t'(w[REF_HI_POS:REF_LO_POS]); // [R6] [R7]
        endcase
        // Reference only changes on a control write
        return nxt; // [R15]
    endfunction

    assign pins_raw = '{sclk: SCLK_IN, din: DIN_IN, cs_n: CS_N_IN};

    ddsw_sync u_sync (
        .clk_in(MCLK_IN),
        .reset_in(RESET_IN),
        .pins_in(pins_raw),
        .pins_out(pins_s)
    );

    always_comb
    begin
        prev_next = pins_s;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
            prev_reg <= PINS_RESET;
        else
            prev_reg <= prev_next;
    end

    assign sclk_fall = prev_reg.sclk & ~pins_s.sclk;
    assign sclk_rise = ~prev_reg.sclk & pins_s.sclk;
    assign cs_fall = prev_reg.cs_n & ~pins_s.cs_n;
    assign cs_rise = ~prev_reg.cs_n & pins_s.cs_n;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        dac_next = dac_reg;
        loaded_next = 1'h0;
        apply_now = 1'h0;
        if (cs_fall)
        begin
            state_next = ST_SHIFT; // [R16]
            cnt_next = CNT_ZERO;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    state_next = ST_IDLE;
                end
                ST_SHIFT:
                begin
                    if (cs_rise)
                    begin
                        // Empty frame carries nothing to load
                        apply_now = (cnt_reg != CNT_ZERO); // [R2]
                        state_next = ST_IDLE;
                    end
                    else if (sclk_fall)
                    begin
                        shift_next = {shift_reg[WORD_BITS-2:0], pins_s.din}; // [R1]
                        cnt_next = cnt_reg + CNT_ONE;
                        if (cnt_reg == CNT_LAST)
                            state_next = ST_WAIT_RISE;
                    end
                end
                ST_WAIT_RISE:
                begin
                    if (cs_rise)
                    begin
                        apply_now = 1'h1; // [R2]
                        state_next = ST_IDLE;
                    end
                    else if (sclk_rise)
                    begin
                        apply_now = 1'h1; // [R9]
                        state_next = ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    // Clocks past the 16th are dropped until select rises
                    if (cs_rise)
                        state_next = ST_IDLE;
                end
            endcase
        end
        if (apply_now)
        begin
            dac_next = apply_word(dac_reg, shift_reg); // [R2]
            loaded_next = 1'h1;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RESET_IN)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
            shift_reg <= WORD_RESET;
            dac_reg <= DAC_RESET;
            loaded_reg <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            dac_reg <= dac_next;
            loaded_reg <= loaded_next;
        end
    end

    assign OUTPUT_FIRST_CODE_OUT = dac_reg.first;
    assign OUTPUT_SECOND_CODE_OUT = dac_reg.second;
    assign BUFFER_CODE_OUT = dac_reg.buffer;
    assign REF_SELECT_OUT = dac_reg.ctrl.ref_sel;
    assign FAST_SETTLE_OUT = dac_reg.ctrl.fast;
    assign POWER_DOWN_OUT = dac_reg.ctrl.pdown;
    assign WORD_LOADED_OUT = loaded_reg;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    shift_msb_a: assert property (state_reg == ST_SHIFT && !cs_fall && !cs_rise && sclk_fall // [R1]
        |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(pins_s.din)} && cnt_reg == $past(cnt_reg) + CNT_ONE)
        else $error("bit not shifted in msb first");
    full_word_a: assert property (state_reg == ST_SHIFT && cnt_reg == CNT_LAST && sclk_fall && !cs_fall && !cs_rise // [R2]
        |=> state_reg == ST_WAIT_RISE && !WORD_LOADED_OUT)
        else $error("16th bit did not arm the load");
    rise_load_a: assert property (state_reg == ST_WAIT_RISE && sclk_rise && !cs_fall // [R9]
        |=> WORD_LOADED_OUT ##1 !WORD_LOADED_OUT)
        else $error("load not on serial clock rise");
    early_cs_a: assert property (state_reg == ST_SHIFT && cs_rise && cnt_reg != CNT_ZERO // [R2]
        |=> WORD_LOADED_OUT && state_reg == ST_IDLE)
        else $error("early select rise did not load");
    target_b_a: assert property (apply_now && shift_reg[TGT_HI_POS] == 1'h0 && shift_reg[TGT_LO_POS] == 1'h0 // [R12]
        |=> OUTPUT_SECOND_CODE_OUT == $past(shift_reg[CODE_MSB_POS:CODE_LSB_POS])
            && BUFFER_CODE_OUT == OUTPUT_SECOND_CODE_OUT && $stable(OUTPUT_FIRST_CODE_OUT))
        else $error("select 00 did not update second output and buffer");
    buf_hold_a: assert property (apply_now && shift_reg[TGT_HI_POS] == 1'h0 && shift_reg[TGT_LO_POS] == 1'h1 // [R11]
        |=> $stable(OUTPUT_SECOND_CODE_OUT) && $stable(OUTPUT_FIRST_CODE_OUT)
            && BUFFER_CODE_OUT == $past(shift_reg[CODE_MSB_POS:CODE_LSB_POS]))
        else $error("buffer-only write touched an output");
    xfer_both_a: assert property (apply_now && shift_reg[TGT_HI_POS] == 1'h1 && shift_reg[TGT_LO_POS] == 1'h0 // [R10]
        |=> OUTPUT_SECOND_CODE_OUT == $past(BUFFER_CODE_OUT)
            && OUTPUT_FIRST_CODE_OUT == $past(shift_reg[CODE_MSB_POS:CODE_LSB_POS]))
        else $error("transfer write did not move both outputs");
    ctrl_ref_a: assert property (apply_now && shift_reg[TGT_HI_POS] == 1'h1 && shift_reg[TGT_LO_POS] == 1'h1 // [R6]
        |=> REF_SELECT_OUT == $past(shift_reg[REF_HI_POS:REF_LO_POS]) && $stable(BUFFER_CODE_OUT))
        else $error("control write did not set reference");
    ref_keep_a: assert property (!apply_now || !(shift_reg[TGT_HI_POS] && shift_reg[TGT_LO_POS]) // [R15]
        |=> $stable(REF_SELECT_OUT))
        else $error("reference changed without control write");
    mode_bits_a: assert property (apply_now // [R13]
        |=> FAST_SETTLE_OUT == $past(shift_reg[SPEED_POS]) && POWER_DOWN_OUT == $past(shift_reg[PWR_POS]))
        else $error("speed or power bit not taken");
    power_only_a: assert property (!apply_now |=> $stable(POWER_DOWN_OUT) && $stable(FAST_SETTLE_OUT)) // [R14]
        else $error("mode changed without a word");
    restart_cnt_a: assert property (cs_fall |=> cnt_reg == CNT_ZERO && state_reg == ST_SHIFT) // [R16]
        else $error("select fall did not restart count");

    full_word_c: cover property (state_reg == ST_WAIT_RISE && sclk_rise ##1 WORD_LOADED_OUT);
    short_word_c: cover property (state_reg == ST_SHIFT && cs_rise && cnt_reg != CNT_ZERO);
    xfer_c: cover property (apply_now && shift_reg[TGT_HI_POS] && !shift_reg[TGT_LO_POS]);
    power_c: cover property (apply_now && shift_reg[PWR_POS]);
endmodule

// file: tb/ddsw_host_model.sv
/*
 Host serial controller model: drives select, serial clock and data.
 Assumes its caller supplies a free-running core clock for frame alignment.
*/
`timescale 1ns/1ps
module ddsw_host_model
(
    input wire logic clk_in,
    output logic sclk_out,
    output logic din_out,
    output logic cs_n_out
);
    initial
    begin
        sclk_out = 1'b1;
        din_out = 1'b1;
        cs_n_out = 1'b1;
    end

    // Serial clock idles high and stands still between frames
    task automatic send(input logic [15:0] word, input int nbits);
        @(posedge clk_in);
        #3;
        cs_n_out = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++)
        begin
            din_out = word[15 - i];
            #40;
            sclk_out = 1'b0;
            #80;
            sclk_out = 1'b1;
            #40;
        end
        #100;
        cs_n_out = 1'b1;
        // Released data line must not keep the last bit
        din_out = ~din_out;
        #200;
    endtask
endmodule

// file: tb/tb.sv
/*
 Self-checking bench for the serial word decoder.
 Assumes the design and the host model are compiled before it.
*/
`timescale 1ns/1ps
module tb
    import ddsw_pkg::*;
;
    logic mclk;
    logic reset;
    logic sclk;
    logic din;
    logic cs_n;
    logic [7:0] first_code;
    logic [7:0] second_code;
    logic [7:0] buf_code;
    logic [1:0] ref_sel;
    logic fast;
    logic pdown;
    logic loaded;
    logic [7:0] e_first;
    logic [7:0] e_second;
    logic [7:0] e_buf;
    logic [1:0] e_ref;
    logic e_fast;
    logic e_pd;
    logic [15:0] sr;
    int n_loaded;
    int e_loads;
    int n_mismatch;
    int num_checks;

    ddsw_top dut (.MCLK_IN(mclk), .RESET_IN(reset), .SCLK_IN(sclk), .DIN_IN(din), .CS_N_IN(cs_n),
        .OUTPUT_FIRST_CODE_OUT(first_code), .OUTPUT_SECOND_CODE_OUT(second_code),
        .BUFFER_CODE_OUT(buf_code), .REF_SELECT_OUT(ref_sel), .FAST_SETTLE_OUT(fast),
        .POWER_DOWN_OUT(pdown), .WORD_LOADED_OUT(loaded));
    ddsw_host_model host (.clk_in(mclk), .sclk_out(sclk), .din_out(din), .cs_n_out(cs_n));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (loaded === 1'b1)
            n_loaded <= n_loaded + 1;

    // Low nibble zero: controller's duty for code words
    function automatic logic [15:0] dac_word(input ddsw_target_t t, input logic s, input logic p,
                                             input logic [7:0] c);
        return {t[1], s, p, t[0], c, 4'h0};
    endfunction

    task automatic check_regs(input string what);
        num_checks++;
        if ({first_code, second_code, buf_code, ref_sel, fast, pdown} !==
            {e_first, e_second, e_buf, e_ref, e_fast, e_pd})
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s outputs %h %h %h %b %b %b", $time, what, first_code,
                     second_code, buf_code, ref_sel, fast, pdown);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: load pulses %0d expected %0d", $time, got, exp);
        end
    endtask

    // Short frames keep older bits in the upper shift positions
    task automatic step(input logic [15:0] w, input int n);
        host.send(w, n);
        if (n > 0)
        begin
            sr = (n == 16) ? w : ((sr << n) | (w >> (16 - n)));
            e_fast = sr[SPEED_POS];
            e_pd = sr[PWR_POS];
            case (ddsw_target_t'({sr[TGT_HI_POS], sr[TGT_LO_POS]}))
                TGT_B_AND_BUF: {e_second, e_buf} = {2{sr[11:4]}};
                TGT_BUF_ONLY: e_buf = sr[11:4];
                TGT_A_XFER_B: {e_first, e_second} = {sr[11:4], e_buf};
                default: e_ref = sr[1:0];
            endcase
            e_loads++;
        end
        check_regs("after word");
        check_count(n_loaded, e_loads);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        reset = 1'b1;
        {e_first, e_second, e_buf, e_ref, e_fast, e_pd} = '0;
        sr = WORD_RESET;
        n_loaded = 0;
        e_loads = 0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (4) @(posedge mclk);
        #3;
        reset = 1'b0;
        repeat (5) @(posedge mclk);
        check_regs("reset");
        // Junk in unused control data bits; external codes stay legal
        for (int r = 0; r < 4; r++)
            step({4'hD ^ {1'b0, r[0], 2'h0}, 10'h2A8, r[1:0]}, 16);
        step(dac_word(TGT_B_AND_BUF, 1'b1, 1'b0, 8'h5A), 16);
        step(dac_word(TGT_BUF_ONLY, 1'b0, 1'b0, 8'h3C), 16);
        step(dac_word(TGT_A_XFER_B, 1'b1, 1'b0, 8'hC3), 16);
        step(16'hF5A6, 16);
        step(dac_word(TGT_B_AND_BUF, 1'b0, 1'b0, 8'h81), 16);
        step(dac_word(TGT_BUF_ONLY, 1'b1, 1'b0, 8'hE7), 8);
        step(dac_word(TGT_A_XFER_B, 1'b0, 1'b0, 8'h42), 16);
        step(16'h0000, 0);
        step(dac_word(TGT_B_AND_BUF, 1'b1, 1'b0, 8'hFF), 5);
        for (int t = 0; t < 4; t++)
            step(dac_word(ddsw_target_t'(t), t[0], 1'b0, 8'h11 * t[7:0] + 8'h0F), 16);
        test_done();
    end
endmodule
